// *** design/atsc_pkg.sv ***
package atsc_pkg;

	// ***************
	// Register map
	// ***************
	localparam logic [7:0] ATSC_CTRL_OFS = 8'h00;
	localparam logic [7:0] ATSC_STAT_OFS = 8'h04;
	localparam logic [7:0] ATSC_MASK_OFS = 8'h08;
	localparam logic [7:0] ATSC_EVENT_OFS = 8'h0C;
	localparam logic [7:0] ATSC_RESULT_OFS = 8'h10;
	localparam logic [7:0] ATSC_BUFLO_OFS = 8'h14;
	localparam logic [7:0] ATSC_BUFHI_OFS = 8'h18;

	// ***************
	// Control field positions
	// ***************
	localparam int ATSC_AUTOSCAN_ENABLE_BIT = 15;
	localparam int ATSC_LP_BIT = 14;
	localparam int ATSC_CHG_BIT = 13;
	localparam int ATSC_REF_BIT = 12;
	localparam int ATSC_IRQ_LSB = 8;
	localparam int ATSC_WM_LSB = 2;
	localparam int ATSC_CM_LSB = 0;
	localparam logic [15:0] ATSC_CTRL_WMASK = 16'hF30F;
	localparam logic [15:0] ATSC_CTRL_RST = 16'h0000;

	// ***************
	// Status bits
	// ***************
	localparam int ATSC_ST_IRQ = 0;
	localparam int ATSC_ST_MATCH = 1;
	localparam int ATSC_ST_STORE = 2;
	localparam int ATSC_ST_DONE = 3;
	localparam int ATSC_ST_W = 4;

	localparam int ATSC_RES_W = 12;

	typedef enum logic [1:0] {
		ATSC_IRQ_DONE_MATCH = 2'b11,
		ATSC_IRQ_MATCH = 2'b10,
		ATSC_IRQ_DONE = 2'b01,
		ATSC_IRQ_NONE = 2'b00
	} atsc_irq_sel_t;

	typedef enum logic [1:0] {
		ATSC_WM_RSVD = 2'b11,
		ATSC_WM_COMPARE = 2'b10,
		ATSC_WM_SAVE = 2'b01,
		ATSC_WM_LEGACY = 2'b00
	} atsc_wm_t;

	typedef enum logic [1:0] {
		ATSC_CM_OUTSIDE = 2'b11,
		ATSC_CM_INSIDE = 2'b10,
		ATSC_CM_GREATER = 2'b01,
		ATSC_CM_LESS = 2'b00
	} atsc_cm_t;

	// Bit-for-bit control layout; reserved fields held at 0 by the mask
	typedef struct packed {
		logic autoscan_enable;
		logic low_power_select;
		logic charge_unit_request;
		logic reference_request;
		logic [1:0] reserved_hi;
		atsc_irq_sel_t scan_irq_select;
		logic [3:0] reserved_lo;
		atsc_wm_t result_write_mode;
		atsc_cm_t match_compare_mode;
	} atsc_ctrl_t;

	typedef struct packed {
		logic [ATSC_RES_W-1:0] value;
		logic [ATSC_RES_W-1:0] buf_lo;
		logic [ATSC_RES_W-1:0] buf_hi;
	} atsc_cmp_in_t;

endpackage

// *** design/atsc_compare.sv ***
module atsc_compare
	import atsc_pkg::*;
#(
	parameter int W = ATSC_RES_W
) (
	input wire logic [W-1:0] value, // Conversion result
	input wire logic [W-1:0] buf_lo, // Buffer value, window low
	input wire logic [W-1:0] buf_hi, // Pair partner, window high
	input wire atsc_cm_t mode, // Compare mode
	output logic match // Valid match
);

	logic in_window;

	always_comb begin
		in_window = (value >= buf_lo) && (value <= buf_hi);
		case (mode)
			ATSC_CM_INSIDE: match = in_window;
			ATSC_CM_OUTSIDE: match = !in_window;
			ATSC_CM_GREATER: match = value > buf_lo;
			ATSC_CM_LESS: match = value < buf_lo;
			default: match = 1'b0;
		endcase
	end

endmodule

// *** design/atsc_ctrl.sv ***
module atsc_ctrl
	import atsc_pkg::*;
(
	input wire logic sys_clk, // 25 MHz clock
	input wire logic rst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic adc_enabled, // Converter on
	input wire logic adc_active, // Converter busy
	input wire logic conv_done, // One-cycle result strobe
	input wire logic [ATSC_RES_W-1:0] conv_result, // Result value
	input wire logic scan_end, // One-cycle scan-complete strobe
	output logic low_power, // Reduced-power mode
	output logic charge_unit_en, // Charge unit enable
	output logic reference_en, // Band-gap enable
	output logic store_strobe, // Write result to buffer
	output logic [ATSC_RES_W-1:0] store_data, // Result to store
	output logic irq // Level interrupt
);

	// ***************
	// State
	// ***************
	atsc_ctrl_t ctrl, next_ctrl;
	logic [ATSC_ST_W-1:0] stat, next_stat;
	logic [ATSC_ST_W-1:0] mask, next_mask;
	logic [ATSC_RES_W-1:0] buf_lo, next_buf_lo;
	logic [ATSC_RES_W-1:0] buf_hi, next_buf_hi;
	logic [ATSC_RES_W-1:0] last_res, next_last_res;
	logic seen_match, next_seen_match;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_low_power, next_charge_unit_en, next_reference_en;
	logic next_store_strobe, next_irq;
	logic [ATSC_RES_W-1:0] next_store_data;
	logic match;
	logic [ATSC_ST_W-1:0] ev;
	logic wr, rd, hit, scan_irq;
	atsc_cmp_in_t cmp;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ATSC_CTRL_OFS) || (a == ATSC_STAT_OFS) ||
			(a == ATSC_MASK_OFS) || (a == ATSC_EVENT_OFS) ||
			(a == ATSC_RESULT_OFS) || (a == ATSC_BUFLO_OFS) ||
			(a == ATSC_BUFHI_OFS);
	endfunction

	assign cmp = '{value: conv_result, buf_lo: buf_lo, buf_hi: buf_hi};

	atsc_compare #(
		.W(ATSC_RES_W)
	) u_cmp (
		.value(cmp.value),
		.buf_lo(cmp.buf_lo),
		.buf_hi(cmp.buf_hi),
		.mode(ctrl.match_compare_mode),
		.match(match)
	);

	// ***************
	// Next-state logic
	// ***************
	always_comb begin
		// ***************
		// Bus decode
		// ***************
		// Write lands at the edge that sees the access cycle's pready
		wr = psel && penable && pwrite && pready;
		rd = psel && !penable;
		hit = is_mapped(paddr);
		next_ctrl = ctrl;
		next_mask = mask;
		next_buf_lo = buf_lo;
		next_buf_hi = buf_hi;
		next_last_res = last_res;
		next_seen_match = seen_match;
		next_store_strobe = 1'b0;
		next_store_data = store_data;
		ev = '0;
		scan_irq = 1'b0;

		if (ctrl.autoscan_enable && conv_done) begin
			if (match) begin
				ev[ATSC_ST_MATCH] = 1'b1;
				next_seen_match = 1'b1;
			end
			// Reserved mode stores nothing so the buffer stays intact
			case (ctrl.result_write_mode)
				ATSC_WM_LEGACY: next_store_strobe = 1'b1;
				ATSC_WM_SAVE: next_store_strobe = match;
				ATSC_WM_COMPARE: next_store_strobe = 1'b0;
				default: next_store_strobe = 1'b0;
			endcase
			if (next_store_strobe) begin
				next_store_data = conv_result;
				next_last_res = conv_result;
				ev[ATSC_ST_STORE] = 1'b1;
			end
		end else if (conv_done) begin
			// Scan off: every result kept, as in legacy mode
			next_store_strobe = 1'b1;
			next_store_data = conv_result;
			next_last_res = conv_result;
			ev[ATSC_ST_STORE] = 1'b1;
		end

		if (ctrl.autoscan_enable) begin
			case (ctrl.scan_irq_select)
				ATSC_IRQ_DONE_MATCH:
					scan_irq = scan_end && next_seen_match;
				ATSC_IRQ_MATCH: scan_irq = ev[ATSC_ST_MATCH];
				ATSC_IRQ_DONE: scan_irq = scan_end;
				default: scan_irq = 1'b0;
			endcase
		end
		ev[ATSC_ST_IRQ] = scan_irq;
		ev[ATSC_ST_DONE] = scan_end;
		// Match memory restarts with each scan
		if (scan_end) begin
			next_seen_match = 1'b0;
		end

		// Set wins over a same-cycle write-one-to-clear
		next_stat = stat;
		if (wr && paddr == ATSC_STAT_OFS) begin
			next_stat = stat & ~pwdata[ATSC_ST_W-1:0];
		end
		next_stat = next_stat | ev;

		if (wr) begin
			case (paddr)
				ATSC_CTRL_OFS:
					next_ctrl = atsc_ctrl_t'(pwdata[15:0] & ATSC_CTRL_WMASK);
				ATSC_MASK_OFS: next_mask = pwdata[ATSC_ST_W-1:0];
				ATSC_BUFLO_OFS: next_buf_lo = pwdata[ATSC_RES_W-1:0];
				ATSC_BUFHI_OFS: next_buf_hi = pwdata[ATSC_RES_W-1:0];
				default: ;
			endcase
		end

		next_prdata = prdata;
		if (rd) begin
			case (paddr)
				ATSC_CTRL_OFS: next_prdata = {16'h0000, 16'(ctrl)};
				ATSC_STAT_OFS: next_prdata = 32'(stat);
				ATSC_MASK_OFS: next_prdata = 32'(mask);
				ATSC_EVENT_OFS: next_prdata = 32'(stat & mask);
				ATSC_RESULT_OFS: next_prdata = 32'(last_res);
				ATSC_BUFLO_OFS: next_prdata = 32'(buf_lo);
				ATSC_BUFHI_OFS: next_prdata = 32'(buf_hi);
				default: next_prdata = 32'h00000000;
			endcase
		end
		next_pready = psel && !penable;
		next_pslverr = psel && !penable && !hit;

		// ***************
		// Outputs
		// ***************
		next_low_power = ctrl.low_power_select;
		next_charge_unit_en = ctrl.charge_unit_request &&
			adc_enabled && adc_active;
		next_reference_en = ctrl.reference_request &&
			adc_enabled && adc_active;
		next_irq = |(next_stat & next_mask);
	end

	// ***************
	// Registers
	// ***************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= atsc_ctrl_t'(ATSC_CTRL_RST);
			stat <= '0;
			mask <= '0;
			buf_lo <= '0;
			buf_hi <= '0;
			last_res <= '0;
			seen_match <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			low_power <= 1'b0;
			charge_unit_en <= 1'b0;
			reference_en <= 1'b0;
			store_strobe <= 1'b0;
			store_data <= '0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			stat <= next_stat;
			mask <= next_mask;
			buf_lo <= next_buf_lo;
			buf_hi <= next_buf_hi;
			last_res <= next_last_res;
			seen_match <= next_seen_match;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			low_power <= next_low_power;
			charge_unit_en <= next_charge_unit_en;
			reference_en <= next_reference_en;
			store_strobe <= next_store_strobe;
			store_data <= next_store_data;
			irq <= next_irq;
		end
	end

endmodule

// *** dv/atsc_ctrl_asserts.sv ***
module atsc_ctrl_asserts
	import atsc_pkg::*;
(
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // APB
	input wire logic penable, // APB
	input wire logic pwrite, // APB
	input wire logic [7:0] paddr, // APB
	input wire logic [31:0] pwdata, // APB
	input wire logic pready, // APB
	input wire logic adc_enabled, // On
	input wire logic adc_active, // Busy
	input wire logic conv_done, // Strobe
	input wire logic [ATSC_RES_W-1:0] conv_result, // Result
	input wire logic scan_end, // Strobe
	input wire logic low_power, // Mode
	input wire logic charge_unit_en, // Enable
	input wire logic reference_en, // Enable
	input wire logic store_strobe, // Store
	input wire logic [ATSC_RES_W-1:0] store_data, // Stored
	input wire logic irq // Level
);
	// ***
	// Cause of an interrupt edge: event or register write
	// ***
	wire ev = conv_done || scan_end || (psel && pwrite);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_ctrl_wr;
		psel && penable && pready && pwrite && paddr == ATSC_CTRL_OFS;
	endsequence
	AST_LOW_POWER: assert property (s_ctrl_wr |-> ##2
		low_power == $past(pwdata[14], 2)) else $error("low_power stale");
	AST_CHARGE: assert property (charge_unit_en |->
		$past(adc_enabled && adc_active)) else $error("charge_unit_en idle");
	AST_REF: assert property (reference_en |->
		$past(adc_enabled && adc_active)) else $error("reference_en idle");
	AST_STORE: assert property (store_strobe |-> $past(conv_done) &&
		store_data == $past(conv_result)) else $error("bad store");
	AST_IRQ_RISE: assert property ($rose(irq) |->
		$past(ev) || $past(ev, 2)) else $error("irq without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |->
		$past(psel && pwrite) || $past(psel && pwrite, 2))
		else $error("irq dropped without write");
endmodule

bind atsc_ctrl atsc_ctrl_asserts u_chk (.sys_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .adc_enabled, .adc_active,
	.conv_done, .conv_result, .scan_end, .low_power, .charge_unit_en,
	.reference_en, .store_strobe, .store_data, .irq);

// *** dv/testbench.sv ***
module testbench
	import atsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = '0, rst = 1'h1, psel = '0, penable = '0, pwrite = '0;
	logic adc_enabled = '0, adc_active = '0, conv_done = '0, scan_end = '0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, sl, low_power, charge_unit_en, reference_en, irq;
	logic store_strobe;
	logic [11:0] conv_result = '0, store_data;
	logic [11:0] vals [5] = '{12'h0FF, 12'h100, 12'h150, 12'h200, 12'h201};
	logic [4:0] cm_exp [4] = '{5'h01, 5'h1C, 5'h0E, 5'h11};
	int miscompares = 0, n_checks = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	atsc_ctrl dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .adc_enabled, .adc_active,
		.conv_done, .conv_result, .scan_end, .low_power, .charge_unit_en,
		.reference_en, .store_strobe, .store_data, .irq);
	// ***
	// Bus and converter tasks
	// ***
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic conv(logic [11:0] v, logic e);
		@(posedge sys_clk);
		conv_done <= 1'h1;
		conv_result <= v;
		@(posedge sys_clk);
		conv_done <= 1'h0;
		@(posedge sys_clk);
		chk("store_strobe", e, store_strobe);
		if (e)
			chk("store_data", v, store_data);
	endtask
	task automatic scan();
		@(posedge sys_clk);
		scan_end <= 1'h1;
		@(posedge sys_clk);
		scan_end <= 1'h0;
	endtask
	task automatic ichk(logic e);
		repeat (3) @(posedge sys_clk);
		chk("irq", e, irq);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'h0;
		apb(1'h0, ATSC_CTRL_OFS, '0);
		chk("ctrl", '0, rd);
		apb(1'h1, ATSC_CTRL_OFS, 32'hFFFF);
		apb(1'h0, ATSC_CTRL_OFS, '0);
		chk("ctrl", 32'hF30F, rd);
		chk("low_power", 1'h1, low_power);
		chk("charge", 1'h0, charge_unit_en);
		adc_enabled <= 1'h1;
		adc_active <= 1'h1;
		ichk(1'h0);
		chk("charge", 1'h1, charge_unit_en);
		chk("reference", 1'h1, reference_en);
		@(posedge sys_clk);
		adc_active <= 1'h0;
		ichk(1'h0);
		chk("charge", 1'h0, charge_unit_en);
		adc_active <= 1'h1;
		apb(1'h1, ATSC_CTRL_OFS, '0);
		ichk(1'h0);
		chk("low_power", 1'h0, low_power);
		chk("reference", 1'h0, reference_en);
		conv(12'h123, 1'h1);
		apb(1'h1, ATSC_BUFLO_OFS, 32'h100);
		apb(1'h1, ATSC_BUFHI_OFS, 32'h200);
		foreach (cm_exp[m]) begin
			apb(1'h1, ATSC_CTRL_OFS, 32'h8004 | m);
			foreach (vals[i])
				conv(vals[i], cm_exp[m][i]);
		end
		apb(1'h1, ATSC_CTRL_OFS, 32'h8000);
		conv(12'h150, 1'h1);
		apb(1'h1, ATSC_CTRL_OFS, 32'h8008);
		conv(12'h0FF, 1'h0);
		apb(1'h1, ATSC_CTRL_OFS, 32'h800C);
		conv(12'h0FF, 1'h0);
		apb(1'h0, ATSC_RESULT_OFS, '0);
		chk("result", 32'h150, rd);
		apb(1'h1, ATSC_MASK_OFS, 32'h1);
		apb(1'h1, ATSC_CTRL_OFS, 32'h8208);
		conv(12'h0FF, 1'h0);
		ichk(1'h1);
		apb(1'h1, ATSC_STAT_OFS, 32'h1);
		ichk(1'h0);
		apb(1'h1, ATSC_CTRL_OFS, 32'h8108);
		conv(12'h0FF, 1'h0);
		ichk(1'h0);
		scan();
		ichk(1'h1);
		apb(1'h1, ATSC_STAT_OFS, 32'h1);
		apb(1'h1, ATSC_CTRL_OFS, 32'h8308);
		scan();
		ichk(1'h0);
		conv(12'h0FF, 1'h0);
		scan();
		ichk(1'h1);
		apb(1'h1, ATSC_MASK_OFS, '0);
		ichk(1'h0);
		apb(1'h0, ATSC_EVENT_OFS, '0);
		chk("event", '0, rd);
		apb(1'h0, 8'h40, '0);
		chk("pslverr", 1'h1, sl);
		chk("unmapped", '0, rd);
		stop_test();
	end
endmodule
